/* design/tmr_defs.vh */
// Register map, field positions, reset values and encodings of the timer
`ifndef TMR_DEFS_VH
`define TMR_DEFS_VH
// ==========================================================
// Register byte offsets
`define TMR_OFF_MODE      8'h00
`define TMR_OFF_PRESCALE  8'h04
`define TMR_OFF_CCA       8'h08
`define TMR_OFF_CCB       8'h0c
`define TMR_OFF_CCCTRL    8'h10
`define TMR_OFF_COUNT     8'h14
`define TMR_OFF_STATUS    8'h18
`define TMR_OFF_MASK      8'h1c
`define TMR_OFF_OVF       8'h20
// ==========================================================
// Field positions
`define TMR_MODE_LO       2
`define TMR_MODE_HI       3
`define TMR_ES_LO         4
`define TMR_ES_HI         5
`define TMR_DIV_LO        0
`define TMR_DIV_HI        1
`define TMR_CC_A_CAP      0
`define TMR_CC_B_CAP      1
`define TMR_CC_OS_EN      2
`define TMR_CC_OS_TRIG    6
`define TMR_ST_MATCH_A    0
`define TMR_ST_MATCH_B    1
`define TMR_ST_OVF        2
// ==========================================================
// Operating modes (two-bit field)
`define TMR_OP_STOP       2'h0
`define TMR_OP_FREE       2'h1
`define TMR_OP_CLR_EDGE   2'h2
`define TMR_OP_CLR_MATCH  2'h3
// Edge selections
`define TMR_ES_FALL       2'h0
`define TMR_ES_RISE       2'h1
`define TMR_ES_NONE       2'h2
`define TMR_ES_BOTH       2'h3
// ==========================================================
// Reset values and counter limits
`define TMR_RST_CC        16'h0000
`define TMR_RST_MASK      3'h0
`define TMR_CNT_MAX       16'hffff
`define TMR_CNT_ZERO      16'h0000
`endif

/* design/tmr_edge_det.v */
// Pin synchroniser with selectable valid-edge detection
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defs.vh"
module tmr_edge_det (
  input  wire       clk,
  input  wire       reset_n,
  input  wire       pin_in,
  input  wire [1:0] edge_sel,
  output wire       valid_edge
);
  reg [2:0] sync_reg;
  reg       level_reg;
  wire      rise;
  wire      fall;

  // ==========================================================
  // Three-stage synchroniser; level changes only when stages 2 and 3 agree
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_reg  <= 3'h0;
      level_reg <= 1'b0;
    end else begin
      sync_reg <= {sync_reg[1:0], pin_in};
      if (sync_reg[1] == sync_reg[2])
        level_reg <= sync_reg[2];
    end
  end

  // Edge found on the filtered level; stage 1 is never looked at
  assign rise = (sync_reg[1] == sync_reg[2]) && sync_reg[2] && !level_reg;
  assign fall = (sync_reg[1] == sync_reg[2]) && !sync_reg[2] && level_reg;

  // Edge selection field picks which transitions count
  assign valid_edge = (edge_sel == `TMR_ES_FALL) ? fall :
                      (edge_sel == `TMR_ES_RISE) ? rise :
                      (edge_sel == `TMR_ES_BOTH) ? (rise | fall) : 1'b0;
endmodule // tmr_edge_det
`default_nettype wire

/* design/tmr_timer16.v */
// 16-bit timer/event counter with two capture/compare registers over APB
//
// Function
// - Capture/compare contents are not guaranteed once the timer stops.
// - Trigger valid edge is chosen by prescaler register bits 4 and 5.
// - External trigger during an active one-shot pulse is ignored.
// - External trigger stays active in software-triggered one-shot use.
// - Counter step from FFFF to 0000 sets overflow in all run modes.
// - Clearing overflow before the counter reaches 0001 is overridden.
// - Counter stays stopped while mode is 00, runs on any other value.
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defs.vh"
module tmr_timer16 #(
  parameter DIV_W = 8
) (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  input  wire        trigger_capture_input_a,
  output reg         pulse_out,
  output wire        irq
);
  // ==========================================================
  // Register state
  reg [1:0]  op_mode_reg;
  reg [1:0]  edge_sel_reg;
  reg [1:0]  div_sel_reg;
  reg [15:0] capture_compare_a;
  reg [15:0] capture_compare_b;
  reg [1:0]  cap_mode_reg;
  reg        oneshot_en_reg;
  reg [15:0] timer_count_value;
  reg [2:0]  status_reg;
  reg [2:0]  mask_reg;
  reg        overflow_flag;
  reg        ovf_hold_reg;
  reg        os_active_reg;
  reg [DIV_W-1:0] div_reg;
  reg [2:0]  rd_clr_reg;

  wire       setup   = psel && !penable;
  wire       wr      = psel && penable && pwrite;
  wire       rd      = psel && penable && !pwrite;
  wire       running = (op_mode_reg != `TMR_OP_STOP);
  wire       trig_edge;
  wire       tick;
  wire       match_a;
  wire       match_b;
  wire       ovf_evt;
  wire       os_trigger;
  wire       sw_trig;
  wire       cnt_clear;
  reg        hit;

  assign pready = 1'b1;

  // ==========================================================
  // Pin synchroniser and edge selection
  tmr_edge_det u_edge (
    .clk        (clk),
    .reset_n    (reset_n),
    .pin_in     (trigger_capture_input_a),
    .edge_sel   (edge_sel_reg),
    .valid_edge (trig_edge)
  );

  // ==========================================================
  // Count clock: divider gives one-cycle enable pulses of 1, 2, 4 or 8
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      div_reg <= {DIV_W{1'b0}};
    else if (!running)
      div_reg <= {DIV_W{1'b0}};
    else
      div_reg <= div_reg + 1'b1;
  end
  assign tick = running &&
                ((div_sel_reg == 2'h0) ||
                 (div_sel_reg == 2'h1 && div_reg[0]) ||
                 (div_sel_reg == 2'h2 && div_reg[1:0] == 2'h3) ||
                 (div_sel_reg == 2'h3 && div_reg[2:0] == 3'h7));

  // ==========================================================
  // Match and overflow events, all on the count tick
  assign match_a = tick && !cap_mode_reg[0] &&
                   (timer_count_value == capture_compare_a);
  assign match_b = tick && !cap_mode_reg[1] &&
                   (timer_count_value == capture_compare_b);
  // Any run mode wraps FFFF to 0000, including a match-clear at FFFF
  assign ovf_evt = tick && (timer_count_value == `TMR_CNT_MAX);

  // One-shot: software or pin edge, both ignored while a pulse is out
  assign sw_trig    = wr && (paddr == `TMR_OFF_CCCTRL) &&
                      pwdata[`TMR_CC_OS_TRIG];
  assign os_trigger = oneshot_en_reg && running && !os_active_reg &&
                      (sw_trig || trig_edge);

  // Counter clears on match A or on a trigger edge, each in its own clear mode, or on a one-shot start
  assign cnt_clear = os_trigger ||
    (op_mode_reg == `TMR_OP_CLR_MATCH && tick &&
     timer_count_value == capture_compare_a) ||
    (op_mode_reg == `TMR_OP_CLR_EDGE && trig_edge && !oneshot_en_reg);

  // ==========================================================
  // Counter; held at zero while stopped
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      timer_count_value <= `TMR_CNT_ZERO;
    else if (!running)
      timer_count_value <= `TMR_CNT_ZERO;
    else if (cnt_clear)
      timer_count_value <= `TMR_CNT_ZERO;
    else if (tick)
      timer_count_value <= timer_count_value + 16'h0001;
  end

  // ==========================================================
  // One-shot pulse: high from match B to match A
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      os_active_reg <= 1'b0;
      pulse_out     <= 1'b0;
    end else if (!running || !oneshot_en_reg) begin
      os_active_reg <= 1'b0;
      pulse_out     <= 1'b0;
    end else if (os_trigger) begin
      os_active_reg <= 1'b1;
      pulse_out     <= 1'b0;
    end else if (os_active_reg) begin
      if (match_a) begin
        os_active_reg <= 1'b0;
        pulse_out     <= 1'b0;
      end else if (match_b) begin
        pulse_out <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Overflow flag; the hold window from 0000 until 0001 re-sets it
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ovf_hold_reg  <= 1'b0;
      overflow_flag <= 1'b0;
    end else begin
      if (ovf_evt)
        ovf_hold_reg <= 1'b1;
      else if (tick || !running)
        ovf_hold_reg <= 1'b0;
      // Set beats clear, and the hold window keeps the clear from acting
      if (ovf_evt || ovf_hold_reg)
        overflow_flag <= 1'b1;
      else if (wr && paddr == `TMR_OFF_OVF && !pwdata[0])
        overflow_flag <= 1'b0;
    end
  end

  // ==========================================================
  // Control registers and capture; writes land in the access phase
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      op_mode_reg       <= `TMR_OP_STOP;
      edge_sel_reg      <= `TMR_ES_FALL;
      div_sel_reg       <= 2'h0;
      capture_compare_a <= `TMR_RST_CC;
      capture_compare_b <= `TMR_RST_CC;
      cap_mode_reg      <= 2'h0;
      oneshot_en_reg    <= 1'b0;
      mask_reg          <= `TMR_RST_MASK;
    end else begin
      if (wr) begin
        case (paddr)
          `TMR_OFF_MODE:
            op_mode_reg <= pwdata[`TMR_MODE_HI:`TMR_MODE_LO];
          `TMR_OFF_PRESCALE: begin
            // Changing the edge while running is software's fault
            edge_sel_reg <= pwdata[`TMR_ES_HI:`TMR_ES_LO];
            div_sel_reg  <= pwdata[`TMR_DIV_HI:`TMR_DIV_LO];
          end
          `TMR_OFF_CCA:    capture_compare_a <= pwdata[15:0];
          `TMR_OFF_CCB:    capture_compare_b <= pwdata[15:0];
          `TMR_OFF_CCCTRL: begin
            cap_mode_reg   <= {pwdata[`TMR_CC_B_CAP], pwdata[`TMR_CC_A_CAP]};
            oneshot_en_reg <= pwdata[`TMR_CC_OS_EN];
          end
          `TMR_OFF_MASK:   mask_reg <= pwdata[2:0];
          default: ;
        endcase
      end
      // Capture on a valid edge while running; a capture wins over a write
      // Stopping does not restore these, so software must reload them
      if (running && trig_edge && cap_mode_reg[0])
        capture_compare_a <= timer_count_value;
      if (running && trig_edge && cap_mode_reg[1])
        capture_compare_b <= timer_count_value;
    end
  end

  // ==========================================================
  // Sticky status; read clears only the bits that were reported
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      status_reg <= 3'h0;
    else
      status_reg <= (status_reg & ~((rd && paddr == `TMR_OFF_STATUS) ?
                                    rd_clr_reg : 3'h0)) |
                    {ovf_evt, match_b, match_a};
  end

  assign irq = |(status_reg & mask_reg);

  // ==========================================================
  // Read data and error latched in the setup phase
  always @* begin
    hit = 1'b1;
    case (paddr)
      `TMR_OFF_MODE, `TMR_OFF_PRESCALE, `TMR_OFF_CCA, `TMR_OFF_CCB,
      `TMR_OFF_CCCTRL, `TMR_OFF_COUNT, `TMR_OFF_STATUS, `TMR_OFF_MASK,
      `TMR_OFF_OVF: hit = 1'b1;
      default:      hit = 1'b0;
    endcase
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata     <= 32'h0000_0000;
      pslverr    <= 1'b0;
      rd_clr_reg <= 3'h0;
    end else if (setup) begin
      pslverr    <= !hit;
      rd_clr_reg <= status_reg;
      case (paddr)
        `TMR_OFF_MODE:     prdata <= {28'h0, op_mode_reg, 2'h0};
        `TMR_OFF_PRESCALE: prdata <= {26'h0, edge_sel_reg, 2'h0,
                                      div_sel_reg};
        `TMR_OFF_CCA:      prdata <= {16'h0, capture_compare_a};
        `TMR_OFF_CCB:      prdata <= {16'h0, capture_compare_b};
        `TMR_OFF_CCCTRL:   prdata <= {29'h0, oneshot_en_reg, cap_mode_reg};
        `TMR_OFF_COUNT:    prdata <= {16'h0, timer_count_value};
        `TMR_OFF_STATUS:   prdata <= {29'h0, status_reg};
        `TMR_OFF_MASK:     prdata <= {29'h0, mask_reg};
        `TMR_OFF_OVF:      prdata <= {31'h0, overflow_flag};
        default:           prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule // tmr_timer16
`default_nettype wire

/* verif/tmr_pin_src.sv */
// Trigger pin source standing in for the external event driver
`timescale 1ns/1ps
`default_nettype none
module tmr_pin_src (
  input  wire logic clk,
  output logic      pin
);
  // Pin rests low and moves only when a trigger is asked for
  initial pin = 1'b0;
  // One clean pulse, long enough for the synchroniser
  task automatic hit;
    pin <= 1'b1;
    repeat (8) @(posedge clk);
    pin <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
endmodule // tmr_pin_src
`default_nettype wire

/* verif/tmr_timer16_monitor.sv */
// Port checker for the timer and its bind
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defs.vh"
module tmr_timer16_monitor #(
  parameter DIV_W = 8
) (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        trigger_capture_input_a,
  input wire logic        pulse_out,
  input wire logic        irq
);
  logic [1:0] mode_q, es_q;
  logic [2:0] mask_q;
  logic       es_ok;
  // Shadow of written fields, updated at the access edge like the design
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_q <= 2'h0;
      es_q   <= 2'h0;
      mask_q <= 3'h0;
      es_ok  <= 1'b0;
    end else if (psel && penable && pwrite) begin
      if (paddr == `TMR_OFF_MODE) mode_q <= pwdata[3:2];
      if (paddr == `TMR_OFF_MASK) mask_q <= pwdata[2:0];
      if (paddr == `TMR_OFF_PRESCALE) begin
        es_q  <= pwdata[5:4];
        es_ok <= 1'b1;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_rd(a);
    psel && penable && !pwrite && paddr == a;
  endsequence
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_unmapped: assert property (psel && penable && paddr > `TMR_OFF_OVF
    |-> pslverr && (pwrite || prdata == 32'h0)) else $error("no error");
  a_err_mapped: assert property (psel && penable && paddr[1:0] == 2'h0 &&
    paddr <= `TMR_OFF_OVF |-> !pslverr) else $error("false error");
  a_trig_reads_zero: assert property (s_rd(`TMR_OFF_CCCTRL) |-> !prdata[6])
    else $error("trigger bit reads one");
  // Count is latched at setup, so the mode must be stop two edges earlier
  a_stop_count_zero: assert property (mode_q == 2'h0 ##2
    s_rd(`TMR_OFF_COUNT) |-> prdata == 32'h0)
    else $error("stopped count moved");
  a_count_upper: assert property (s_rd(`TMR_OFF_COUNT)
    |-> prdata[31:16] == 16'h0) else $error("count upper bits set");
  a_edge_back: assert property (s_rd(`TMR_OFF_PRESCALE) ##0 es_ok
    |-> prdata[5:4] == es_q) else $error("edge field lost");
  a_irq_masked: assert property (mask_q == 3'h0 [*2] |-> !irq)
    else $error("masked irq high");
endmodule // tmr_timer16_monitor
bind tmr_timer16 tmr_timer16_monitor #(.DIV_W(DIV_W)) u_mon (
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .pulse_out(pulse_out), .irq(irq),
  .trigger_capture_input_a(trigger_capture_input_a));
`default_nettype wire

/* verif/tmr_timer16_tb.sv */
// Self-checking bench for the timer over APB and its trigger pin
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defs.vh"
module tmr_timer16_tb;
  logic        clk, reset_n, psel, penable, pwrite, last_err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, q;
  wire         pready, pslverr, pin, pulse_out, irq;
  wire  [31:0] prdata;
  int          fail_count, num_checks, n;
  tmr_timer16 #(.DIV_W(8)) DUT (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq),
    .trigger_capture_input_a(pin), .pulse_out(pulse_out));
  tmr_pin_src src (.clk(clk), .pin(pin));
  // =========================================
  // Clock and tasks
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // One APB transfer; idle edge after it keeps psel from two writes a step
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask
  // Pulse width in clocks, both waits bounded
  task automatic measure(output int len);
    for (int i = 0; i < 300 && pulse_out !== 1'b1; i++) @(posedge clk);
    len = 0;
    while (pulse_out === 1'b1 && len < 300) begin
      @(posedge clk);
      len++;
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog above the full wrap of the counter, under the cycle budget
  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    close_out();
  end
  // =========================================
  // Tests
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    reset_n = 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    xfer(0, `TMR_OFF_COUNT, 0); chk("count stop", q, 0);
    xfer(0, 8'h40, 0); chk("unmapped err", last_err, 1);
    chk("unmapped data", q, 0);
    xfer(1, `TMR_OFF_PRESCALE, 32'h10);
    xfer(0, `TMR_OFF_PRESCALE, 0); chk("edge sel", q & 32'h30, 32'h10);
    // Overflow with compare A at full scale, slowed near the wrap
    xfer(1, `TMR_OFF_CCA, 32'hffff);
    xfer(1, `TMR_OFF_MODE, 32'h4);
    xfer(0, `TMR_OFF_COUNT, 0); chk("count runs", q === 32'h0, 0);
    for (n = 0; n < 40000 && q[15:8] !== 8'hff; n++)
      xfer(0, `TMR_OFF_COUNT, 0);
    xfer(1, `TMR_OFF_PRESCALE, 32'h13);
    q = 32'h0;
    // About 250 ticks of 8 clocks remain, so the poll must outlast them
    for (n = 0; n < 1000 && q[0] !== 1'b1; n++) xfer(0, `TMR_OFF_OVF, 0);
    chk("ovf set", q, 1);
    xfer(1, `TMR_OFF_OVF, 0);
    xfer(0, `TMR_OFF_OVF, 0); chk("ovf reset", q, 1);
    repeat (20) @(posedge clk);
    xfer(1, `TMR_OFF_OVF, 0);
    xfer(0, `TMR_OFF_OVF, 0); chk("ovf clear", q, 0);
    chk("irq masked", irq, 0);
    xfer(1, `TMR_OFF_MASK, 32'h4); chk("irq on", irq, 1);
    xfer(0, `TMR_OFF_STATUS, 0); chk("st ovf", q & 32'h4, 32'h4);
    chk("irq off", irq, 0);
    // One-shot, software then pin trigger with a second edge mid-pulse
    xfer(1, `TMR_OFF_MODE, 0);
    xfer(1, `TMR_OFF_PRESCALE, 32'h10);
    xfer(1, `TMR_OFF_CCA, 32'h40);
    xfer(1, `TMR_OFF_CCB, 32'h10);
    xfer(1, `TMR_OFF_CCCTRL, 32'h4);
    xfer(0, `TMR_OFF_STATUS, 0);
    xfer(1, `TMR_OFF_MODE, 32'h4);
    xfer(1, `TMR_OFF_CCCTRL, 32'h44);
    measure(n); chk("sw pulse", n, 48);
    xfer(0, `TMR_OFF_STATUS, 0); chk("matches", q & 32'h3, 32'h3);
    fork
      begin
        src.hit();
        repeat (30) @(posedge clk);
        src.hit();
      end
    join_none
    measure(n); chk("pin pulse", n, 48);
    // Clear on match A, then clear and capture B on a pin edge
    xfer(1, `TMR_OFF_MODE, 0);
    xfer(1, `TMR_OFF_CCA, 32'h20);
    xfer(1, `TMR_OFF_CCB, 32'h8);
    xfer(1, `TMR_OFF_CCCTRL, 0);
    xfer(0, `TMR_OFF_STATUS, 0);
    xfer(1, `TMR_OFF_MODE, 32'hc);
    repeat (100) @(posedge clk);
    xfer(0, `TMR_OFF_COUNT, 0);
    chk("match clear", q <= 32'h20, 1);
    xfer(0, `TMR_OFF_STATUS, 0); chk("match a", q & 32'h1, 1);
    xfer(1, `TMR_OFF_MODE, 0);
    xfer(1, `TMR_OFF_CCCTRL, 32'h2);
    xfer(1, `TMR_OFF_MODE, 32'h8);
    // Without the edge clear the count would stand at 17 here
    src.hit();
    xfer(0, `TMR_OFF_COUNT, 0); chk("edge clear", q < 32'h10, 1);
    xfer(0, `TMR_OFF_CCB, 0); chk("capture b", q > 0 && q < 32'h10, 1);
    xfer(1, `TMR_OFF_MODE, 0);
    xfer(0, `TMR_OFF_COUNT, 0); chk("count held", q, 0);
    close_out();
  end
endmodule // tmr_timer16_tb
`default_nettype wire
